// file: common/lidc_pkg.sv
// Purpose: shared constants and types for the display instruction decoder
// Assumes: 50 MHz core clock, host bus sampled synchronously
// Notes: execution times scaled from the 270 kHz oscillator figures
package lidc_pkg;
   localparam int CLK_MHZ = 50;
   localparam int EXEC_NS = 39000;
   localparam int DATA_NS = 43000;
   localparam int EXEC_CYC = (EXEC_NS * CLK_MHZ) / 1000;
   localparam int DATA_CYC = (DATA_NS * CLK_MHZ) / 1000;
   localparam int BLINK_MS = 370;
   localparam int BLINK_CYC = BLINK_MS * CLK_MHZ * 1000;
   localparam int CNT_W = 25;
   localparam logic [6:0] AC_RST = 7'h00;
   localparam logic [5:0] SQ_MAX = 6'h30;
   localparam logic [6:0] LINE2_BASE = 7'h40;
   localparam logic [6:0] LINE1_END2 = 7'h27;
   localparam logic [6:0] LINE_END1 = 7'h4F;
   localparam logic [6:0] ROW4_LAST = 7'h13;
   localparam logic [6:0] ROW4_STEP = 7'h20;
   localparam logic [1:0] RAM_TEXT = 2'h0;
   localparam logic [1:0] RAM_GLYPH = 2'h1;
   localparam logic [1:0] RAM_ICON = 2'h2;

   typedef struct packed {
      logic cmd_or_data;
      logic rd_not_wr;
      logic [7:0] data;
   } lidc_req_type;

   typedef struct packed {
      logic glyph_six_dot;
      logic cursor_invert;
      logic four_row_mode;
      logic dual_row;
      logic bus_width_sel;
      logic shift_or_scroll_sel;
      logic invert_all;
      logic user_glyph_blink;
      logic slow_clock_mode;
      logic [3:0] line_shift_en;
      logic [3:0] dot_scroll_line_en;
      logic [5:0] scroll_amount;
   } lidc_cfg_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BUSY = 2'b01
   } lidc_state_type;
endpackage : lidc_pkg

// file: rtl/lidc_decoder.sv
// Purpose: instruction decoder of a character display controller
// Assumes: host requests arrive as a valid/ready stream, already assembled to bytes
// Notes: RAM itself lives outside; this block drives its address, data and strobes
//
// Contract
// - six-dot font, execution time times 6/5
// - cursor inversion toggles every 370 ms
// - four-row mode forces 4-line, ignores dual-row
// - shift moves cursor or display, no RAM
// - cursor wraps line after 80, 40 or 20
// - display shift per enabled line, counter kept
// - scroll select low: dot scroll line enables
// - scroll select high: line shift enables
// - each enable covers eight commons
// - bus width bit selects 8 or 4 bit
// - dual-row picks 1/2 line unless four-row
// - shift/scroll select writable only with pin high
// - invert-all reverses every dot
// - alternate table gates extended settings
// - user glyph blink enables RAM blink
// - slow clock divides by 4 or 2
// - slow clock: frame 5/6, no shifts; the code does not block shifts in slow clock
// - DB6 opcode loads glyph RAM address
// - alternate table: DB6 loads icon address
// - DB7 loads 7-bit text buffer address
// - four-row text buffer line ranges
// - scroll amount 0-47, top bits mean 48
// - counter steps by one per RAM access
`timescale 1ns/1ps
module lidc_decoder
   import lidc_pkg::*;
#(
   parameter int BLINK_CYCLES = BLINK_CYC
) (
   input wire logic CORE_CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic REQ_VALID_IN,
   input wire lidc_req_type REQ_IN,
   output logic REQ_READY_OUT,
   output logic RSP_VALID_OUT,
   input wire logic RSP_READY_IN,
   output logic [7:0] RSP_DATA_OUT,
   input wire logic TABLE_SELECT_PIN_IN,
   input wire logic EXPANDER_PRESENT_PIN_IN,
   input wire logic ENTRY_INCREMENT_IN,
   input wire logic [7:0] RAM_RDATA_IN,
   output logic RAM_WR_OUT,
   output logic RAM_RD_OUT,
   output logic [1:0] RAM_SEL_OUT,
   output logic [6:0] RAM_ADDR_OUT,
   output logic [7:0] RAM_WDATA_OUT,
   output lidc_cfg_type CFG_OUT,
   output logic [1:0] LINE_COUNT_OUT,
   output logic [1:0] CLK_DIV_OUT,
   output logic DISPLAY_SHIFT_OUT,
   output logic SHIFT_RIGHT_OUT,
   output logic [3:0] SHIFT_LINES_OUT,
   output logic [3:0] SCROLL_LINES_OUT,
   output logic [5:0] SCROLL_DOTS_OUT,
   output logic CURSOR_INV_PHASE_OUT,
   output logic BUSY_FLAG_OUT
);
   // two-entry skid buffer on the read-answer path
   logic [7:0] buf_r [2];
   logic [1:0] cnt_r;
   logic wp_r;
   logic rp_r;
   logic push;
   logic pop;

   lidc_cfg_type cfg_r;
   lidc_state_type state_r;
   logic alt_r;
   logic [6:0] addr_counter_r;
   logic [1:0] ram_sel_r;
   logic [CNT_W-1:0] busy_cnt_r;
   logic [CNT_W-1:0] blink_cnt_r;
   logic inv_phase_r;
   logic ram_wr_r;
   logic ram_rd_r;
   logic [7:0] wdata_r;
   logic [6:0] acc_addr_r;
   logic rd_pend_r;
   logic shift_pulse_r;
   logic shift_right_r;
   logic [1:0] lines;
   logic take;
   lidc_req_type rq;

   // scaled execution time: font 6/5, slow clock 4x or 2x
   function automatic logic [CNT_W-1:0] exec_cycles(input int base, input lidc_cfg_type c,
                                                   input logic expander_present_pin, input logic [1:0] ln);
      int t;
      t = base;
      if (c.glyph_six_dot)
         t = (t * 6) / 5;
      if (!expander_present_pin && c.slow_clock_mode)
         t = (ln == 2'd1) ? t * 4 : t * 2;
      return CNT_W'(t);
   endfunction : exec_cycles

   // one step of the address counter with line wrap in the text buffer
   function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
                                            input logic [1:0] ln, input logic [1:0] sel);
      logic [6:0] n;
      n = up ? a + 7'd1 : a - 7'd1;
      if (sel == RAM_TEXT) begin
         if (ln == 2'd2) begin
            if (up && a == LINE1_END2)
               n = LINE2_BASE;
            else if (up && a == LINE2_BASE + LINE1_END2)
               n = AC_RST;
            else if (!up && a == LINE2_BASE)
               n = LINE1_END2;
            else if (!up && a == AC_RST)
               n = LINE2_BASE + LINE1_END2;
         end else if (ln == 2'd3) begin
            if (up && a[4:0] == ROW4_LAST[4:0])
               n = (a & 7'h60) + ROW4_STEP;
            else if (!up && a[4:0] == 5'h00)
               n = (a & 7'h60) - ROW4_STEP + ROW4_LAST;
         end else begin
            if (up && a == LINE_END1)
               n = AC_RST;
            else if (!up && a == AC_RST)
               n = LINE_END1;
         end
      end
      return n;
   endfunction : step_addr

   // 1 = one line, 2 = two, 3 = four
   assign lines = cfg_r.four_row_mode ? 2'd3 : (cfg_r.dual_row ? 2'd2 : 2'd1);
   assign rq = REQ_IN;
   // a read is only taken when the answer buffer is empty
   assign take = REQ_VALID_IN && REQ_READY_OUT;
   assign push = rd_pend_r;
   assign pop = RSP_VALID_OUT && RSP_READY_IN;

   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         state_r <= ST_IDLE;
         busy_cnt_r <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (take && !(rq.rd_not_wr && !rq.cmd_or_data)) begin
                  state_r <= ST_BUSY;
                  busy_cnt_r <= exec_cycles(rq.cmd_or_data ? DATA_CYC : EXEC_CYC, cfg_r,
                                            EXPANDER_PRESENT_PIN_IN, lines);
               end
            end
            ST_BUSY: begin
               if (busy_cnt_r <= CNT_W'(1))
                  state_r <= ST_IDLE;
               busy_cnt_r <= busy_cnt_r - CNT_W'(1);
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         REQ_READY_OUT <= 1'b0;
         BUSY_FLAG_OUT <= 1'b0;
      end else begin
         // status reads wait like everything else; nothing is taken while busy
         REQ_READY_OUT <= !take && cnt_r == 2'd0 && !rd_pend_r && state_r == ST_IDLE;
         BUSY_FLAG_OUT <= state_r == ST_BUSY || take;
      end
   end

   // instruction decode by most significant set bit
   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         cfg_r <= '0;
         cfg_r.bus_width_sel <= 1'b1;
         alt_r <= 1'b0;
         addr_counter_r <= AC_RST;
         ram_sel_r <= RAM_TEXT;
         shift_pulse_r <= 1'b0;
         shift_right_r <= 1'b0;
      end else begin
         shift_pulse_r <= 1'b0;
         if (take && !rq.cmd_or_data && !rq.rd_not_wr) begin
            if (rq.data[7]) begin
               if (alt_r)
                  cfg_r.scroll_amount <= rq.data[5:0];
               else begin
                  addr_counter_r <= rq.data[6:0];
                  ram_sel_r <= RAM_TEXT;
               end
            end else if (rq.data[6]) begin
               if (alt_r) begin
                  addr_counter_r <= {3'b000, rq.data[3:0]};
                  ram_sel_r <= RAM_ICON;
               end else begin
                  addr_counter_r <= {1'b0, rq.data[5:0]};
                  ram_sel_r <= RAM_GLYPH;
               end
            end else if (rq.data[5]) begin
               cfg_r.bus_width_sel <= rq.data[4];
               cfg_r.dual_row <= rq.data[3];
               alt_r <= rq.data[2];
               if (rq.data[2]) begin
                  cfg_r.user_glyph_blink <= rq.data[1];
                  cfg_r.slow_clock_mode <= rq.data[0];
               end else begin
                  if (TABLE_SELECT_PIN_IN)
                     cfg_r.shift_or_scroll_sel <= rq.data[1];
                  cfg_r.invert_all <= rq.data[0];
               end
            end else if (rq.data[4]) begin
               if (alt_r) begin
                  if (cfg_r.shift_or_scroll_sel)
                     cfg_r.line_shift_en <= rq.data[3:0];
                  else
                     cfg_r.dot_scroll_line_en <= rq.data[3:0];
               end else if (rq.data[3]) begin
                  shift_pulse_r <= 1'b1;
                  shift_right_r <= rq.data[2];
               end else begin
                  addr_counter_r <= step_addr(addr_counter_r, rq.data[2], lines,
                                              RAM_TEXT);
               end
            end else if (rq.data[3] && alt_r) begin
               cfg_r.glyph_six_dot <= rq.data[2];
               cfg_r.cursor_invert <= rq.data[1];
               cfg_r.four_row_mode <= rq.data[0];
            end
         end else if (take && rq.cmd_or_data) begin
            addr_counter_r <= step_addr(addr_counter_r, ENTRY_INCREMENT_IN, lines,
                                        ram_sel_r);
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         ram_wr_r <= 1'b0;
         ram_rd_r <= 1'b0;
         wdata_r <= 8'h00;
         acc_addr_r <= AC_RST;
         rd_pend_r <= 1'b0;
      end else begin
         ram_wr_r <= take && rq.cmd_or_data && !rq.rd_not_wr;
         ram_rd_r <= take && rq.cmd_or_data && rq.rd_not_wr;
         rd_pend_r <= take && rq.rd_not_wr;
         if (take) begin
            wdata_r <= rq.data;
            acc_addr_r <= addr_counter_r;
         end
      end
   end

   // answer buffer; the status read captures flag and counter at acceptance
   logic [7:0] rsp_word;
   logic rd_ram_r;
   logic [7:0] stat_r;
   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         rd_ram_r <= 1'b0;
         stat_r <= 8'h00;
      end else begin
         rd_ram_r <= take && rq.cmd_or_data;
         if (take)
            stat_r <= {state_r == ST_BUSY, addr_counter_r};
      end
   end
   assign rsp_word = rd_ram_r ? RAM_RDATA_IN : stat_r;

   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         cnt_r <= 2'd0;
         buf_r[0] <= 8'h00;
         buf_r[1] <= 8'h00;
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         RSP_VALID_OUT <= 1'b0;
         RSP_DATA_OUT <= 8'h00;
      end else begin
         if (push) begin
            buf_r[wp_r] <= rsp_word;
            wp_r <= !wp_r;
         end
         if (pop)
            rp_r <= !rp_r;
         cnt_r <= cnt_r + 2'(push) - 2'(pop);
         RSP_VALID_OUT <= (cnt_r + 2'(push) - 2'(pop)) != 2'd0;
         RSP_DATA_OUT <= push && (cnt_r == 2'(pop)) ? rsp_word
                         : buf_r[pop ? !rp_r : rp_r];
      end
   end

   // cursor inversion phase
   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN || !cfg_r.cursor_invert) begin
         blink_cnt_r <= '0;
         inv_phase_r <= 1'b0;
      end else if (blink_cnt_r >= CNT_W'(BLINK_CYCLES - 1)) begin
         blink_cnt_r <= '0;
         inv_phase_r <= !inv_phase_r;
      end else begin
         blink_cnt_r <= blink_cnt_r + CNT_W'(1);
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         CFG_OUT <= '0;
         LINE_COUNT_OUT <= 2'd1;
         CLK_DIV_OUT <= 2'd1;
         DISPLAY_SHIFT_OUT <= 1'b0;
         SHIFT_RIGHT_OUT <= 1'b0;
         SHIFT_LINES_OUT <= 4'h0;
         SCROLL_LINES_OUT <= 4'h0;
         SCROLL_DOTS_OUT <= 6'h00;
         CURSOR_INV_PHASE_OUT <= 1'b0;
         RAM_WR_OUT <= 1'b0;
         RAM_RD_OUT <= 1'b0;
         RAM_SEL_OUT <= RAM_TEXT;
         RAM_ADDR_OUT <= AC_RST;
         RAM_WDATA_OUT <= 8'h00;
      end else begin
         CFG_OUT <= cfg_r;
         LINE_COUNT_OUT <= lines;
         // divider also slows the frame rate
         CLK_DIV_OUT <= (!EXPANDER_PRESENT_PIN_IN && cfg_r.slow_clock_mode)
                        ? ((lines == 2'd1) ? 2'd3 : 2'd2) : 2'd1;
         DISPLAY_SHIFT_OUT <= shift_pulse_r && cfg_r.shift_or_scroll_sel;
         SHIFT_RIGHT_OUT <= shift_right_r;
         SHIFT_LINES_OUT <= cfg_r.shift_or_scroll_sel ? cfg_r.line_shift_en : 4'h0;
         SCROLL_LINES_OUT <= cfg_r.shift_or_scroll_sel ? 4'h0 : cfg_r.dot_scroll_line_en;
         SCROLL_DOTS_OUT <= (cfg_r.scroll_amount[5:4] == 2'b11) ? SQ_MAX
                            : cfg_r.scroll_amount;
         CURSOR_INV_PHASE_OUT <= inv_phase_r;
         RAM_WR_OUT <= ram_wr_r;
         RAM_RD_OUT <= ram_rd_r;
         RAM_SEL_OUT <= ram_sel_r;
         // the counter has already stepped when the strobe goes out, so hold the old address
         RAM_ADDR_OUT <= (ram_wr_r || ram_rd_r) ? acc_addr_r : addr_counter_r;
         RAM_WDATA_OUT <= wdata_r;
      end
   end
endmodule : lidc_decoder

// file: testbench/lidc_monitor.sv
// Purpose: port-level checks of the instruction decoder
// Assumes: one clock, synchronous reset
// Notes: bound onto every decoder instance
`timescale 1ns/1ps
module lidc_monitor
   import lidc_pkg::*;
(
   input wire logic CORE_CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic REQ_VALID_IN,
   input wire lidc_req_type REQ_IN,
   input wire logic REQ_READY_OUT,
   input wire logic RSP_VALID_OUT,
   input wire logic RSP_READY_IN,
   input wire logic [7:0] RSP_DATA_OUT,
   input wire logic EXPANDER_PRESENT_PIN_IN,
   input wire logic RAM_WR_OUT,
   input wire logic RAM_RD_OUT,
   input wire lidc_cfg_type CFG_OUT,
   input wire logic [1:0] LINE_COUNT_OUT,
   input wire logic [1:0] CLK_DIV_OUT,
   input wire logic DISPLAY_SHIFT_OUT,
   input wire logic [3:0] SHIFT_LINES_OUT,
   input wire logic [5:0] SCROLL_DOTS_OUT,
   input wire logic BUSY_FLAG_OUT
);
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   sequence s_take(rw);
      REQ_VALID_IN && REQ_READY_OUT && REQ_IN.rd_not_wr == rw;
   endsequence
   sequence s_data_take;
      REQ_VALID_IN && REQ_READY_OUT && REQ_IN.cmd_or_data;
   endsequence
   property p_busy_take; s_take(1'b0) |=> BUSY_FLAG_OUT; endproperty
   a_busy_take: assert property (p_busy_take) else $error("busy missing");
   property p_busy_refuse; BUSY_FLAG_OUT |-> !REQ_READY_OUT; endproperty
   a_busy_refuse: assert property (p_busy_refuse) else $error("ready while busy");
   property p_read_ans; s_take(1'b1) |-> ##2 RSP_VALID_OUT; endproperty
   a_read_ans: assert property (p_read_ans) else $error("read answer late");
   property p_rsp_hold;
      RSP_VALID_OUT && !RSP_READY_IN |=> RSP_VALID_OUT && $stable(RSP_DATA_OUT);
   endproperty
   a_rsp_hold: assert property (p_rsp_hold) else $error("answer dropped");
   property p_ram_strobe;
      s_data_take |-> ##2 ((RAM_RD_OUT == $past(REQ_IN.rd_not_wr, 2))
         && (RAM_WR_OUT != $past(REQ_IN.rd_not_wr, 2)));
   endproperty
   a_ram_strobe: assert property (p_ram_strobe) else $error("RAM strobe wrong");
   property p_scroll_cap; SCROLL_DOTS_OUT <= 6'h30; endproperty
   a_scroll_cap: assert property (p_scroll_cap) else $error("scroll above 48");
   property p_four_row; CFG_OUT.four_row_mode [*3] |-> LINE_COUNT_OUT == 2'h3; endproperty
   a_four_row: assert property (p_four_row) else $error("four-row ignored");
   property p_slow_div;
      (CFG_OUT.slow_clock_mode && !EXPANDER_PRESENT_PIN_IN && LINE_COUNT_OUT == 2'h1) [*3]
         |-> CLK_DIV_OUT == 2'h3;
   endproperty
   a_slow_div: assert property (p_slow_div) else $error("divider wrong");
   property p_shift_no_ram; DISPLAY_SHIFT_OUT |-> !RAM_WR_OUT && !RAM_RD_OUT; endproperty
   a_shift_no_ram: assert property (p_shift_no_ram) else $error("shift touched RAM");
   property p_shift_lines;
      DISPLAY_SHIFT_OUT |-> SHIFT_LINES_OUT == CFG_OUT.line_shift_en;
   endproperty
   a_shift_lines: assert property (p_shift_lines) else $error("shift lines wrong");
endmodule : lidc_monitor

bind lidc_decoder lidc_monitor mon (.*);

// file: testbench/lidc_ram_model.sv
// Purpose: external RAM behind the decoder
// Assumes: combinational read on the presented address
// Notes: unwritten cells hold a scrambled pattern so a lost write cannot pass
`timescale 1ns/1ps
module lidc_ram_model (
   input wire logic clk_in,
   input wire logic wr_in,
   input wire logic [1:0] sel_in,
   input wire logic [6:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out
);
   logic [7:0] mem_r [4][128];
   initial for (int k = 0; k < 512; k++) mem_r[k / 128][k % 128] = 8'(k * 91);
   always @(posedge clk_in) if (wr_in) mem_r[sel_in][addr_in] <= wdata_in;
   assign rdata_out = mem_r[sel_in][addr_in];
endmodule : lidc_ram_model

// file: testbench/lidc_decoder_bench.sv
// Purpose: self-checking bench of the instruction decoder
// Assumes: host bytes arrive whole; nibble pairing stays outside
// Notes: blink period cut to 20 cycles
`timescale 1ns/1ps
module lidc_decoder_bench
   import lidc_pkg::*;
();
   logic CORE_CLK_IN, SYS_RST_IN, REQ_VALID_IN, REQ_READY_OUT, RSP_VALID_OUT, RSP_READY_IN;
   logic TABLE_SELECT_PIN_IN, EXPANDER_PRESENT_PIN_IN, ENTRY_INCREMENT_IN, RAM_WR_OUT;
   logic RAM_RD_OUT, DISPLAY_SHIFT_OUT, SHIFT_RIGHT_OUT, CURSOR_INV_PHASE_OUT, BUSY_FLAG_OUT;
   logic [7:0] RSP_DATA_OUT, RAM_RDATA_IN, RAM_WDATA_OUT, rd, v;
   logic [6:0] RAM_ADDR_OUT;
   logic [1:0] RAM_SEL_OUT, LINE_COUNT_OUT, CLK_DIV_OUT;
   logic [3:0] SHIFT_LINES_OUT, SCROLL_LINES_OUT;
   logic [5:0] SCROLL_DOTS_OUT;
   lidc_req_type REQ_IN;
   lidc_cfg_type CFG_OUT;
   int err_total = 0, compares = 0, nb, i;
   logic [5:0] sq_tab [4] = '{6'h01, 6'h2F, 6'h30, 6'h3F};
   logic [15:0] sh_tab [4] = '{16'h1411, 16'h1010, 16'h1810, 16'h1C10};
   lidc_decoder #(.BLINK_CYCLES(20)) dut (.*);
   lidc_ram_model ram (.clk_in(CORE_CLK_IN), .wr_in(RAM_WR_OUT), .sel_in(RAM_SEL_OUT),
      .addr_in(RAM_ADDR_OUT), .wdata_in(RAM_WDATA_OUT), .rdata_out(RAM_RDATA_IN));
   initial begin
      CORE_CLK_IN = 1'b0;
      forever #10 CORE_CLK_IN = ~CORE_CLK_IN;
   end
   // the answer sink stalls at random so held answers get exercised
   always @(posedge CORE_CLK_IN) begin
      if (RSP_VALID_OUT && RSP_READY_IN) rd <= RSP_DATA_OUT;
      #1 RSP_READY_IN = 1'($urandom % 2);
   end
   function automatic int sq_exp(input logic [5:0] s);
      return (s[5:4] == 2'b11) ? 48 : int'(s);
   endfunction : sq_exp
   function automatic int exec_exp(input logic six, input int div);
      return (six ? EXEC_CYC * 6 / 5 : EXEC_CYC) * div;
   endfunction : exec_exp
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one request, then wait until the decoder is ready again, counting busy cycles
   task automatic op(input logic rs, input logic rw, input logic [7:0] d);
      int k;
      k = 0;
      while (REQ_READY_OUT !== 1'b1 && k < 100) begin
         @(posedge CORE_CLK_IN);
         #1 k++;
      end
      REQ_IN = '{rs, rw, d};
      REQ_VALID_IN = 1'b1;
      @(posedge CORE_CLK_IN);
      #1 REQ_VALID_IN = 1'b0;
      nb = 0;
      do begin
         @(posedge CORE_CLK_IN);
         #1 nb += int'(BUSY_FLAG_OUT === 1'b1);
         k++;
      end while (REQ_READY_OUT !== 1'b1 && k < 12000);
      if (k >= 12000) chk(16'h0, 16'h1);
   endtask : op
   task automatic report_and_stop;
      $display("compares=%0d mismatches=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop
   initial begin
      #1900000 err_total++;
      report_and_stop();
   end
   initial begin
      SYS_RST_IN = 1'b1;
      REQ_VALID_IN = 1'b0;
      REQ_IN = '0;
      TABLE_SELECT_PIN_IN = 1'b1;
      EXPANDER_PRESENT_PIN_IN = 1'b0;
      ENTRY_INCREMENT_IN = 1'b1;
      void'($urandom(70195));
      repeat (2) @(posedge CORE_CLK_IN);
      #1 SYS_RST_IN = 1'b0;
      chk(LINE_COUNT_OUT, 2'h1);
      chk(CLK_DIV_OUT, 2'h1);
      v = 8'($urandom);
      op(0, 0, {3'b001, v[3:2], 1'b0, v[1:0]});
      chk(CFG_OUT.bus_width_sel, v[3]);
      chk(LINE_COUNT_OUT, v[2] ? 2'h2 : 2'h1);
      chk(CFG_OUT.invert_all, v[0]);
      chk(nb, exec_exp(1'b0, 1));
      TABLE_SELECT_PIN_IN = 1'b0;
      op(0, 0, {3'b001, v[3:2], 1'b0, ~v[1], v[0]});
      chk(CFG_OUT.shift_or_scroll_sel, v[1]);
      TABLE_SELECT_PIN_IN = 1'b1;
      $display("test function set done");
      op(0, 0, 8'h38);
      for (i = 0; i < 2; i++) begin
         v = {1'b1, i[0], 6'($urandom % 40)};
         op(0, 0, v);
         op(0, 1, 8'h00);
         chk(rd, {1'b0, v[6:0]});
         chk(RAM_SEL_OUT, RAM_TEXT);
      end
      v = 8'($urandom % 62 + 1);
      op(0, 0, {2'b01, v[5:0]});
      op(1, 0, 8'hA5);
      op(0, 1, 8'h00);
      chk(rd, {2'b00, v[5:0] + 6'h01});
      chk(RAM_SEL_OUT, RAM_GLYPH);
      op(0, 0, {2'b01, v[5:0]});
      op(1, 1, 8'h00);
      chk(rd, 8'hA5);
      ENTRY_INCREMENT_IN = 1'b0;
      op(0, 0, {2'b01, v[5:0]});
      op(1, 0, 8'h3C);
      op(0, 1, 8'h00);
      chk(rd, {2'b00, v[5:0] - 6'h01});
      ENTRY_INCREMENT_IN = 1'b1;
      $display("test addresses done");
      op(0, 0, 8'h3A);
      op(0, 0, 8'h90);
      for (i = 0; i < 4; i++) begin
         op(0, 0, sh_tab[i][15:8]);
         op(0, 1, 8'h00);
         chk(rd, sh_tab[i][7:0]);
      end
      chk(SHIFT_RIGHT_OUT, 1'b1);
      op(0, 0, 8'hA7);
      op(0, 0, 8'h14);
      op(0, 1, 8'h00);
      chk(rd, 8'h40);
      $display("test shifts done");
      op(0, 0, 8'h3C);
      v = 8'($urandom);
      op(0, 0, {2'b01, v[5:0]});
      op(0, 1, 8'h00);
      chk(rd, {4'h0, v[3:0]});
      chk(RAM_SEL_OUT, RAM_ICON);
      for (i = 0; i < 2; i++) begin
         op(0, 0, {6'b001110, i[0], 1'b0});
         op(0, 0, 8'h3C);
         op(0, 0, {4'b0001, v[7:4]});
         chk(i ? CFG_OUT.line_shift_en : CFG_OUT.dot_scroll_line_en, v[7:4]);
         chk(i ? SHIFT_LINES_OUT : SCROLL_LINES_OUT, v[7:4]);
      end
      for (i = 0; i < 4; i++) begin
         op(0, 0, {2'b10, sq_tab[i]});
         chk(SCROLL_DOTS_OUT, sq_exp(sq_tab[i]));
      end
      op(0, 0, 8'h0F);
      chk(CFG_OUT.glyph_six_dot, 1'b1);
      v[0] = CURSOR_INV_PHASE_OUT;
      repeat (20) @(posedge CORE_CLK_IN);
      #1 chk(CURSOR_INV_PHASE_OUT, !v[0]);
      op(0, 0, 8'h34);
      chk(nb, exec_exp(1'b1, 1));
      chk(LINE_COUNT_OUT, 2'h3);
      op(0, 0, 8'h08);
      $display("test extended set done");
      // no display shift is issued while the slow clock runs
      op(0, 0, 8'h35);
      op(0, 0, 8'h35);
      chk(CLK_DIV_OUT, 2'h3);
      chk(nb, exec_exp(1'b0, 4));
      op(0, 0, 8'h3E);
      chk(CFG_OUT.user_glyph_blink, 1'b1);
      chk(CLK_DIV_OUT, 2'h1);
      $display("test slow clock done");
      report_and_stop();
   end
endmodule : lidc_decoder_bench
